// ---- smb_pkg.sv ----
// Package with the constants and carrier types of the byte register serial slave.
`default_nettype none
package smb_pkg;
    // ****************************************************************
    // Address byte layout
    // ****************************************************************
    localparam logic [3:0] SMB_CLASS_NIBBLE = 4'h5; // Upper nibble that names the controller class.
    localparam int SMB_CLASS_HI = 7; // Top bit of the class nibble.
    localparam int SMB_CLASS_LO = 4; // Bottom bit of the class nibble.
    localparam int SMB_FIXED_BIT = 3; // Address bit that must be one.
    localparam int SMB_DIR_BIT = 0; // Direction bit, one for a read.
    localparam logic [3:0] SMB_BITS_PER_BYTE = 4'h8; // Bits in one serial byte.
    localparam int SMB_MSB = 7; // Bit sent first on the wire.

    // ****************************************************************
    // Register file layout
    // ****************************************************************
    localparam int SMB_REG_COUNT = 4; // Registers behind the port.
    localparam logic [7:0] SMB_IDX_BRIGHT = 8'h00; // Brightness register index.
    localparam logic [7:0] SMB_IDX_CONTROL = 8'h01; // Device control register index.
    localparam logic [7:0] SMB_IDX_STATUS = 8'h02; // Fault and status register index.
    localparam logic [7:0] SMB_IDX_IDENT = 8'h03; // Identification register index.
    localparam logic [7:0] SMB_RST_BRIGHT = 8'hff; // Brightness after reset.
    localparam logic [7:0] SMB_RST_CONTROL = 8'h00; // Control after reset.
    localparam logic [7:0] SMB_MASK_CONTROL = 8'h07; // Implemented control bits.
    localparam logic [7:0] SMB_MASK_STATUS = 8'h3f; // Implemented status bits.
    localparam logic [7:0] SMB_IDENT_VALUE = 8'h42; // Value is arbitrary.
    localparam logic [7:0] SMB_RST_INDEX = 8'h00; // Command index after reset.
    localparam logic [7:0] SMB_RST_BYTE = 8'h00; // Shift register after reset.
    localparam logic [3:0] SMB_RST_COUNT = 4'h0; // Bit counter after reset.

    // One write into the register file.
    typedef struct packed {
        logic en;
        logic [7:0] index;
        logic [7:0] data;
    } smb_write_t;

    // Sampled bus lines of the current and the previous cycle.
    typedef struct packed {
        logic scl;
        logic sda;
    } smb_lines_t;
endpackage
`default_nettype wire

// ---- smb_regs.sv ----
// Byte wide register file with registered read data and undervoltage defaults.
`timescale 1ns/1ns
`default_nettype none
module smb_regs (
    // Clock and resets.
    input wire logic clock,
    input wire logic reset,
    input wire logic uvlo,
    // Write request and read index.
    input wire smb_pkg::smb_write_t wr,
    input wire logic [7:0] rd_index,
    // Live status bits of the driver.
    input wire logic [7:0] status_in,
    // Registered read data and settings.
    output logic [7:0] rd_data,
    output logic [7:0] brightness,
    output logic [7:0] control
);
    import smb_pkg::*;

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    logic [7:0] next_brightness; // Next brightness value.
    logic [7:0] next_control; // Next control value.
    logic [7:0] next_rd_data; // Next read data.

    // Writes land only at the addressed index; reserved bits are masked away.
    always_comb begin
        next_brightness = brightness;
        next_control = control;
        if (uvlo) begin
            // Lockout forces every setting back to its default.
            next_brightness = SMB_RST_BRIGHT;
            next_control = SMB_RST_CONTROL;
        end else if (wr.en) begin
            if (wr.index == SMB_IDX_BRIGHT) begin
                next_brightness = wr.data;
            end
            if (wr.index == SMB_IDX_CONTROL) begin
                next_control = wr.data & SMB_MASK_CONTROL;
            end
        end
    end

    // Read mux; unmapped indices read zero so a stray query is harmless.
    always_comb begin
        case (rd_index)
            SMB_IDX_BRIGHT: next_rd_data = brightness;
            SMB_IDX_CONTROL: next_rd_data = control;
            SMB_IDX_STATUS: next_rd_data = status_in & SMB_MASK_STATUS;
            SMB_IDX_IDENT: next_rd_data = SMB_IDENT_VALUE;
            default: next_rd_data = SMB_RST_BYTE;
        endcase
    end

    // Register stage.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            brightness <= SMB_RST_BRIGHT;
            control <= SMB_RST_CONTROL;
            rd_data <= SMB_RST_BYTE;
        end else begin
            brightness <= next_brightness;
            control <= next_control;
            rd_data <= next_rd_data;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_uvlo_defaults: assert property (@(posedge clock) disable iff (reset)
        uvlo |=> (brightness == SMB_RST_BRIGHT) && (control == SMB_RST_CONTROL))
        else $error("Lockout did not restore defaults.");
    a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
        (control & ~SMB_MASK_CONTROL) == 8'h00)
        else $error("Reserved control bit is set.");
endmodule
`default_nettype wire

// ---- smb_slave.sv ----
// Serial byte register slave: address decode, command index, byte write and read.
// Function
// - Write: address, command, data byte stored.
// - Command byte selects the target register.
// - Read: address, command, restart, data returned.
// - Returned byte equals selected register contents.
// - Device drives data only in own cycles.
// - Upper address nibble must equal class value.
// - Address bit three must be one.
// - Address bit zero selects read or write.
// - Byte registers; reserved bits read zero.
// - Enable low keeps port silent.
// - Undervoltage lockout restores all register defaults.
`timescale 1ns/1ns
`default_nettype none
module smb_slave (
    // Clock and resets.
    input wire logic clock,
    input wire logic reset,
    input wire logic uvlo,
    // Chip enable, high to run.
    input wire logic enable,
    // Serial bus, clock only received, data open drain.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Driver status and settings.
    input wire logic [7:0] status_in,
    output logic [7:0] brightness,
    output logic [7:0] control
);
    import smb_pkg::*;

    // ****************************************************************
    // Bus condition detection
    // ****************************************************************
    typedef enum {
        SMB_IDLE, SMB_ADDR, SMB_ACK_ADDR, SMB_CMD, SMB_ACK_CMD,
        SMB_DATA, SMB_ACK_DATA, SMB_READ, SMB_HOST_ACK, SMB_IGNORE
    } smb_state_t;

    smb_lines_t prev; // Lines seen one cycle ago.
    smb_lines_t next_prev; // Lines now.
    logic scl_rise; // Clock went high.
    logic scl_fall; // Clock went low.
    logic start_seen; // Start or repeated start.
    logic stop_seen; // Stop condition.

    // Lines are synchronous already, so one stage is enough for edge finding.
    always_comb begin
        next_prev.scl = scl_in;
        next_prev.sda = sda_in;
        scl_rise = scl_in && !prev.scl;
        scl_fall = !scl_in && prev.scl;
        start_seen = scl_in && prev.scl && prev.sda && !sda_in;
        stop_seen = scl_in && prev.scl && !prev.sda && sda_in;
    end

    // ****************************************************************
    // Protocol state
    // ****************************************************************
    smb_state_t state; // Protocol state.
    smb_state_t next_state; // Next protocol state.
    logic [7:0] shift; // Byte being received or sent.
    logic [7:0] next_shift; // Next shift value.
    logic [3:0] count; // Bits moved in this byte.
    logic [3:0] next_count; // Next bit count.
    logic [7:0] index; // Register index from the command byte.
    logic [7:0] next_index; // Next index.
    logic reading; // Address byte asked for a read.
    logic next_reading; // Next direction.
    smb_write_t wr; // Write request to the register file.
    logic [7:0] rd_data; // Registered read data.
    logic addr_match; // Received byte names this device.

    // Decode the address byte; the direction bit is left out of the match.
    function automatic logic smb_addr_hit(input logic [7:0] a);
        smb_addr_hit = (a[SMB_CLASS_HI:SMB_CLASS_LO] == SMB_CLASS_NIBBLE)
            && a[SMB_FIXED_BIT];
    endfunction

    // Next state; each received byte is sampled on clock rises and judged on the fall after its eighth bit.
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_count = count;
        next_index = index;
        next_reading = reading;
        addr_match = smb_addr_hit(shift);
        wr.en = 1'b0;
        wr.index = index;
        wr.data = shift;
        if (!enable) begin
            // A disabled chip ignores the bus entirely.
            next_state = SMB_IDLE;
            next_count = SMB_RST_COUNT;
        end else if (stop_seen) begin
            next_state = SMB_IDLE;
        end else if (start_seen) begin
            // A repeated start restarts address decode but keeps the index.
            next_state = SMB_ADDR;
            next_count = SMB_RST_COUNT;
        end else begin
            case (state)
                SMB_ADDR, SMB_CMD, SMB_DATA: begin
                    if (scl_rise) begin
                        next_shift = {shift[SMB_MSB-1:0], sda_in};
                        next_count = count + 4'h1;
                    end else if (scl_fall && count == SMB_BITS_PER_BYTE) begin
                        next_count = SMB_RST_COUNT;
                        if (state == SMB_ADDR) begin
                            next_reading = shift[SMB_DIR_BIT];
                            next_state = addr_match ? SMB_ACK_ADDR : SMB_IGNORE;
                        end else if (state == SMB_CMD) begin
                            next_index = shift;
                            next_state = SMB_ACK_CMD;
                        end else begin
                            wr.en = 1'b1;
                            next_state = SMB_ACK_DATA;
                        end
                    end
                end
                SMB_ACK_ADDR: begin
                    if (scl_fall) begin
                        // For a read the selected byte is loaded as the ack ends.
                        next_shift = rd_data;
                        next_state = reading ? SMB_READ : SMB_CMD;
                    end
                end
                SMB_ACK_CMD: begin
                    if (scl_fall) begin
                        next_state = SMB_DATA;
                    end
                end
                SMB_ACK_DATA: begin
                    // Only one data byte per write; later bytes get no ack.
                    if (scl_fall) begin
                        next_state = SMB_IGNORE;
                    end
                end
                SMB_READ: begin
                    if (scl_fall) begin
                        next_shift = {shift[SMB_MSB-1:0], 1'b0};
                        next_count = count + 4'h1;
                        if (count == SMB_BITS_PER_BYTE - 4'h1) begin
                            next_state = SMB_HOST_ACK;
                            next_count = SMB_RST_COUNT;
                        end
                    end
                end
                SMB_HOST_ACK: begin
                    // A host ack asks for the same register again; a nack ends the read.
                    if (scl_rise) begin
                        next_state = sda_in ? SMB_IGNORE : SMB_ACK_ADDR;
                    end
                end
                SMB_IDLE, SMB_IGNORE: begin
                    next_count = SMB_RST_COUNT;
                end
                default: begin
                    next_state = SMB_IDLE;
                end
            endcase
        end
    end

    // Host ack path reuses the ack state only as a loader, so it must not drive there.
    logic host_reload; // Set while the ack state serves a host ack.
    logic next_host_reload; // Next reload flag.
    always_comb begin
        next_host_reload = host_reload;
        if (state == SMB_HOST_ACK && next_state == SMB_ACK_ADDR) begin
            next_host_reload = 1'b1;
        end else if (next_state != SMB_ACK_ADDR) begin
            next_host_reload = 1'b0;
        end
    end

    // Register stage of the protocol.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= SMB_IDLE;
            prev <= '1;
            shift <= SMB_RST_BYTE;
            count <= SMB_RST_COUNT;
            index <= SMB_RST_INDEX;
            reading <= 1'b0;
            host_reload <= 1'b0;
        end else begin
            state <= next_state;
            prev <= next_prev;
            shift <= next_shift;
            count <= next_count;
            index <= next_index;
            reading <= next_reading;
            host_reload <= next_host_reload;
        end
    end

    // ****************************************************************
    // Data line drive
    // ****************************************************************
    // Open drain: the pin is only ever pulled low, and only in the device's own cycles.
    always_comb begin
        sda_out = 1'b0;
        sda_oe = 1'b0;
        if (enable) begin
            if ((state == SMB_ACK_ADDR && !host_reload) || state == SMB_ACK_CMD
                || state == SMB_ACK_DATA) begin
                sda_oe = 1'b1;
            end else if (state == SMB_READ) begin
                sda_oe = !shift[SMB_MSB];
            end
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    smb_regs u_regs (
        .clock(clock),
        .reset(reset),
        .uvlo(uvlo),
        .wr(wr),
        .rd_index(index),
        .status_in(status_in),
        .rd_data(rd_data),
        .brightness(brightness),
        .control(control)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_silent_disabled: assert property (@(posedge clock) disable iff (reset)
        !enable |-> !sda_oe)
        else $error("Data line driven while disabled.");
    a_class_mismatch: assert property (@(posedge clock) disable iff (reset)
        (enable && !stop_seen && !start_seen && state == SMB_ADDR && scl_fall && count == 4'h8
        && shift[7:4] != 4'h5) |=> state == SMB_IGNORE && !sda_oe)
        else $error("Foreign class address was taken.");
    a_fixed_bit: assert property (@(posedge clock) disable iff (reset)
        (enable && !stop_seen && !start_seen && state == SMB_ADDR && scl_fall && count == 4'h8
        && !shift[3]) |=> !sda_oe)
        else $error("Address with bit three low was acknowledged.");
    a_ack_match: assert property (@(posedge clock) disable iff (reset)
        (enable && !stop_seen && !start_seen && state == SMB_ADDR && scl_fall && count == 4'h8
        && shift[7:3] == 5'h0b) |=> sda_oe && state == SMB_ACK_ADDR)
        else $error("Matching address not acknowledged.");
    a_write_index: assert property (@(posedge clock) disable iff (reset)
        wr.en |-> wr.index == index && state == SMB_DATA && !reading)
        else $error("Write aimed away from the command index.");
    a_write_lands: assert property (@(posedge clock) disable iff (reset)
        (wr.en && wr.index == 8'h00 && !uvlo) |=> brightness == $past(shift))
        else $error("Data byte was not stored.");
    a_read_load: assert property (@(posedge clock) disable iff (reset)
        (enable && !stop_seen && !start_seen && state == SMB_ACK_ADDR && scl_fall && reading)
        |=> state == SMB_READ && shift == $past(rd_data))
        else $error("Read byte differs from the selected register.");
    a_own_cycles: assert property (@(posedge clock) disable iff (reset)
        sda_oe |-> state inside {SMB_ACK_ADDR, SMB_ACK_CMD, SMB_ACK_DATA, SMB_READ})
        else $error("Data line driven outside device cycles.");
    a_read_no_write: assert property (@(posedge clock) disable iff (reset)
        (state == SMB_READ) [*2] |-> !wr.en && reading)
        else $error("Read transaction wrote a register.");
endmodule
`default_nettype wire

// ---- smb_host.sv ----
// Behavioural host master that runs byte write and byte read transactions on the serial bus.
`timescale 1ns/1ns
`default_nettype none
module smb_host (
    // Bench clock.
    input wire logic clock,
    // Resolved data line.
    input wire logic sda_in,
    // Lines driven by the host; sda_pull high pulls data low.
    output logic scl,
    output logic sda_pull,
    // Answers of the slave, one strobe per acknowledge or read byte.
    output logic res_strobe,
    output logic [7:0] res_val
);
    // ****************************************************************
    // Timing and addresses
    // ****************************************************************
    localparam int PHASE = 4; // Clocks per half bit, twice the minimum so the slave sampler has slack.
    localparam logic [7:0] ADDR_WR = 8'h58; // Address byte for a write.
    localparam logic [7:0] ADDR_RD = 8'h59; // Address byte for a read.

    // The bus idles released, clock stands high between frames.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        res_strobe = 1'b0;
        res_val = 8'h00;
    end

    // ****************************************************************
    // Bus primitives
    // ****************************************************************
    // Waits n edges and steps just past the last one.
    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask

    // Hands one answer to the bench for exactly one clock.
    task automatic publish(input logic [7:0] v);
        res_val = v;
        res_strobe = 1'b1;
        ticks(1);
        res_strobe = 1'b0;
    endtask

    // One bit; data changes only while the clock is low, released when b is one.
    task automatic bit_cycle(input logic b, output logic s);
        ticks(PHASE / 2);
        sda_pull = !b;
        ticks(PHASE / 2);
        scl = 1'b1;
        ticks(PHASE);
        s = sda_in;
        scl = 1'b0;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start_cond();
        ticks(PHASE / 2);
        sda_pull = 1'b0;
        ticks(PHASE / 2);
        scl = 1'b1;
        ticks(PHASE);
        sda_pull = 1'b1;
        ticks(PHASE);
        scl = 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the bus stays idle.
    task automatic stop_cond();
        ticks(PHASE / 2);
        sda_pull = 1'b1;
        ticks(PHASE / 2);
        scl = 1'b1;
        ticks(PHASE);
        sda_pull = 1'b0;
        ticks(PHASE);
    endtask

    // Eight bits MSB first, then the acknowledge clock with data released.
    task automatic send_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, ack_n);
        publish({7'h00, ack_n});
    endtask

    // Eight bits from the slave, then an acknowledge if more follow, else a not-acknowledge.
    task automatic recv_byte(input logic more);
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        bit_cycle(!more, s);
        publish(d);
    endtask

    // ****************************************************************
    // Transactions
    // ****************************************************************
    // Address, command, data, stop; a refused address ends the frame at once.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] cmd, input logic [7:0] data);
        logic a;
        start_cond();
        send_byte(addr, a);
        if (a == 1'b0) begin
            send_byte(cmd, a);
            send_byte(data, a);
        end
        stop_cond();
    endtask

    // Address, command, repeated start, read address, data, nack, stop.
    // With twice set the host acks the first byte, so the same register comes back once more.
    task automatic read_reg(input logic [7:0] cmd, input logic twice);
        logic a;
        start_cond();
        send_byte(ADDR_WR, a);
        send_byte(cmd, a);
        start_cond();
        send_byte(ADDR_RD, a);
        if (twice) begin
            recv_byte(1'b1);
        end
        recv_byte(1'b0);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// ---- smb_slave_bench.sv ----
// Self-checking bench of the byte register serial slave against a host model.
`timescale 1ns/1ns
`default_nettype none
module smb_slave_bench;
    import smb_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clock, reset, uvlo, enable, sda_in, sda_out, sda_oe;
    logic scl, sda_pull, res_strobe;
    logic [7:0] status_in, brightness, control, res_val;
    logic [31:0] seed = 32'h000085f3; // Fixed seed so every run is the same.
    logic [7:0] expect_q[$]; // Expected answers, oldest first.
    logic [7:0] bad_addr[4] = '{8'h78, 8'h18, 8'h50, 8'h52}; // Refused address bytes.
    int n_mismatch = 0;
    int n_checks = 0;

    // Open-drain wire with a pull-up: low when either party pulls.
    assign sda_in = !(sda_pull || (sda_oe && !sda_out));

    smb_slave smb_slave_inst (.clock(clock), .reset(reset), .uvlo(uvlo), .enable(enable),
        .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .status_in(status_in), .brightness(brightness), .control(control));
    smb_host smb_host_inst (.clock(clock), .sda_in(sda_in), .scl(scl), .sda_pull(sda_pull),
        .res_strobe(res_strobe), .res_val(res_val));

    // 10 MHz clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction

    task automatic next_rand(output logic [7:0] r);
        seed = xorshift(seed);
        r = seed[7:0];
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A refused address gives one nack and nothing more.
    task automatic do_write(input logic [7:0] addr, input logic [7:0] cmd, input logic [7:0] data,
                            input logic acked);
        repeat (acked ? 3 : 1) expect_q.push_back({7'h00, !acked});
        smb_host_inst.write_reg(addr, cmd, data);
    endtask

    // A host ack after the data byte asks for the same register once more.
    task automatic do_read(input logic [7:0] cmd, input logic [7:0] exp, input logic twice);
        repeat (3) expect_q.push_back(8'h00);
        repeat (twice ? 2 : 1) expect_q.push_back(exp);
        smb_host_inst.read_reg(cmd, twice);
    endtask

    // ****************************************************************
    // Answer watcher
    // ****************************************************************
    // Every strobe from the host model consumes the oldest note.
    always @(posedge clock) begin
        if (res_strobe === 1'b1) begin
            if (expect_q.size() > 0) begin
                check(res_val, expect_q.pop_front());
            end else begin
                n_mismatch++;
                $display("MISMATCH at %0t: answer with no note", $time);
            end
        end
    end

    // Watchdog sized well above the roughly 3850 clocks of the sequence.
    initial begin
        #(100 * 40000);
        n_mismatch++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] v;
        reset = 1'b1;
        uvlo = 1'b0;
        enable = 1'b1;
        status_in = 8'h00;
        repeat (5) @(posedge clock);
        #10;
        reset = 1'b0;
        ticks(2);
        check(brightness, SMB_RST_BRIGHT);
        check(control, SMB_RST_CONTROL);
        // Random brightness values, each read back straight after.
        for (int k = 0; k < 3; k++) begin
            next_rand(v);
            do_write(8'h58, SMB_IDX_BRIGHT, v, 1'b1);
            check(brightness, v);
            do_read(SMB_IDX_BRIGHT, v, k == 1);
        end
        // Reserved control bits are dropped and read as zero.
        do_write(8'h58, SMB_IDX_CONTROL, 8'hff, 1'b1);
        check(control, 8'h07);
        do_read(SMB_IDX_CONTROL, 8'h07, 1'b0);
        next_rand(status_in);
        do_read(SMB_IDX_STATUS, status_in & SMB_MASK_STATUS, 1'b0);
        do_read(SMB_IDX_IDENT, SMB_IDENT_VALUE, 1'b0);
        do_read(8'h04, 8'h00, 1'b0);
        // Foreign class and missing fixed bit are ignored.
        foreach (bad_addr[i]) begin
            do_write(bad_addr[i], SMB_IDX_BRIGHT, ~v, 1'b0);
            check(brightness, v);
        end
        // Disabled port neither answers nor stores.
        enable = 1'b0;
        ticks(2);
        do_write(8'h58, SMB_IDX_BRIGHT, ~v, 1'b0);
        check(brightness, v);
        enable = 1'b1;
        ticks(2);
        // One lockout edge restores every default.
        uvlo = 1'b1;
        ticks(1);
        uvlo = 1'b0;
        ticks(1);
        check(brightness, SMB_RST_BRIGHT);
        check(control, SMB_RST_CONTROL);
        ticks(10);
        check(8'(expect_q.size()), 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
